// ### bench/periph_reset_ctrl_test.sv
// Self-checking bench for the peripheral reset control registers
`timescale 1ns/10ps
`default_nettype none
module periph_reset_ctrl_test;
    import periph_reset_pkg::*;
    logic clk_sys = 1'b0, rst_b = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0;
    logic [11:0] addr = 12'h000;
    logic [31:0] wdata = 32'h0, mask_a = 32'hffff_ffff, mask_b = 32'hffff_ffff, rdata, v;
    logic [4:0] outs_a;
    logic [11:0] outs_b;
    int errors = 0, checks_done = 0;
    periph_reset_ctrl dut_u (.clk_sys(clk_sys), .rst_b(rst_b), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .capability_mask_a(mask_a),
        .capability_mask_b(mask_b), .can_controller_zero_reset(outs_a[4]),
        .pwm_module_reset(outs_a[3]), .adc_zero_reset(outs_a[2]),
        .hibernation_unit_reset(outs_a[1]), .watchdog_unit_reset(outs_a[0]),
        .comparator_two_reset(outs_b[11]), .comparator_one_reset(outs_b[10]),
        .comparator_zero_reset(outs_b[9]), .gp_timer_two_reset(outs_b[8]),
        .gp_timer_one_reset(outs_b[7]), .gp_timer_zero_reset(outs_b[6]),
        .two_wire_unit_zero_reset(outs_b[5]), .quadrature_decoder_zero_reset(outs_b[4]),
        .sync_serial_zero_reset(outs_b[3]), .async_serial_two_reset(outs_b[2]),
        .async_serial_one_reset(outs_b[1]), .async_serial_zero_reset(outs_b[0]));
    initial begin
        forever #4 clk_sys = ~clk_sys;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        wr_stb <= 1'b1; addr <= a; wdata <= d;
        @(posedge clk_sys);
        wr_stb <= 1'b0;
        #1;
    endtask
    // Read data stand only in the cycle after the strobe, so sample there
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        rd_stb <= 1'b1; addr <= a;
        @(posedge clk_sys);
        rd_stb <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic chk_outs(input logic [31:0] a, input logic [31:0] b);
        chk({27'h0, outs_a}, {27'h0, a[24], a[20], a[16], a[6], a[3]});
        chk({20'h0, outs_b}, {20'h0, b[26:24], b[18:16], b[12], b[8], b[4], b[2:0]});
    endtask
    task automatic test_reset_state();
        rd(OFFSET_RESET_A, v); chk(v, 32'h0);
        rd(OFFSET_RESET_B, v); chk(v, 32'h0);
        chk_outs(32'h0, 32'h0);
    endtask
    task automatic test_set_all();
        wr(OFFSET_RESET_A, 32'hffff_ffff);
        wr(OFFSET_RESET_B, 32'hffff_ffff);
        chk_outs(32'h0111_0048, 32'h0707_1117);
        rd(OFFSET_RESET_A, v); chk(v, 32'h0111_0048);
        rd(OFFSET_RESET_B, v); chk(v, 32'h0707_1117);
        #8 chk(rdata, 32'h0);
    endtask
    // Only the bits whose unit is reported present may change on a write
    task automatic test_masked();
        mask_a <= 32'h0000_0008;
        mask_b <= 32'h0100_0001;
        wr(OFFSET_RESET_A, 32'h0);
        wr(OFFSET_RESET_B, 32'h0);
        rd(OFFSET_RESET_A, v); chk(v, 32'h0111_0040);
        rd(OFFSET_RESET_B, v); chk(v, 32'h0607_1116);
        chk_outs(32'h0111_0040, 32'h0607_1116);
        mask_a <= 32'hffff_ffff;
        mask_b <= 32'hffff_ffff;
        wr(OFFSET_RESET_A, 32'h0000_0008);
        wr(OFFSET_RESET_B, 32'h0000_0101);
        chk_outs(32'h0000_0008, 32'h0000_0101);
    endtask
    task automatic test_unmapped();
        wr(12'h048, 32'hffff_ffff);
        rd(12'h048, v); chk(v, 32'h0);
        rd(OFFSET_RESET_A, v); chk(v, 32'h0000_0008);
        rd(OFFSET_RESET_B, v); chk(v, 32'h0000_0101);
    endtask
    // A reset in mid-run must clear both registers and every reset line
    task automatic test_mid_reset();
        @(posedge clk_sys);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_b <= 1'b1;
        #1 chk_outs(32'h0, 32'h0);
        rd(OFFSET_RESET_A, v); chk(v, 32'h0);
        rd(OFFSET_RESET_B, v); chk(v, 32'h0);
    endtask
    task automatic results();
        $display("Checks %0d, errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk_sys);
        rst_b <= 1'b1;
        test_reset_state();
        test_set_all();
        test_masked();
        test_unmapped();
        test_mid_reset();
        results();
    end
    // The whole sequence takes well under a thousand cycles
    initial begin
        #100000;
        errors++;
        results();
    end
endmodule // periph_reset_ctrl_test
`default_nettype wire

// ### src/periph_reset_ctrl.sv
// Peripheral software reset control registers with capability masking
`timescale 1ns/10ps
`default_nettype none
module periph_reset_ctrl
    import periph_reset_pkg::*;
#(
    parameter int ADDR_WIDTH = REG_ADDR_WIDTH,
    parameter int DATA_WIDTH = REG_DATA_WIDTH
)
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [ADDR_WIDTH-1:0] addr,
    input wire logic [DATA_WIDTH-1:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [DATA_WIDTH-1:0] rdata,
    input wire logic [31:0] capability_mask_a,
    input wire logic [31:0] capability_mask_b,
    output logic can_controller_zero_reset,
    output logic pwm_module_reset,
    output logic adc_zero_reset,
    output logic hibernation_unit_reset,
    output logic watchdog_unit_reset,
    output logic comparator_zero_reset,
    output logic comparator_one_reset,
    output logic comparator_two_reset,
    output logic gp_timer_zero_reset,
    output logic gp_timer_one_reset,
    output logic gp_timer_two_reset,
    output logic two_wire_unit_zero_reset,
    output logic quadrature_decoder_zero_reset,
    output logic sync_serial_zero_reset,
    output logic async_serial_zero_reset,
    output logic async_serial_one_reset,
    output logic async_serial_two_reset
);
    logic [31:0] reset_a_reg;
    logic [31:0] reset_b_reg;
    logic [31:0] reset_a_next;
    logic [31:0] reset_b_next;
    logic [31:0] wmask_a;
    logic [31:0] wmask_b;
    logic sel_a;
    logic sel_b;

    // Bit layout is fixed and offsets need the full compare, so other widths are refused
    if (DATA_WIDTH != REG_DATA_WIDTH || ADDR_WIDTH != REG_ADDR_WIDTH) begin : g_bad_width
        $error("Unsupported address or data width");
    end

    assign sel_a = (addr == OFFSET_RESET_A);
    assign sel_b = (addr == OFFSET_RESET_B);

    // Writes leave the bits of absent units unchanged, so their reset outputs keep their value
    assign wmask_a = WRITABLE_A & capability_mask_a;
    assign wmask_b = WRITABLE_B & capability_mask_b;

    assign reset_a_next = (reset_a_reg & ~wmask_a) | (wdata & wmask_a);
    assign reset_b_next = (reset_b_reg & ~wmask_b) | (wdata & wmask_b);

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            reset_a_reg <= RESET_A_INIT;
        end else if (wr_stb && sel_a) begin
            reset_a_reg <= reset_a_next;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            reset_b_reg <= RESET_B_INIT;
        end else if (wr_stb && sel_b) begin
            reset_b_reg <= reset_b_next;
        end
    end

    // Unmapped addresses read zero; data valid only the cycle after the strobe
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            rdata <= RDATA_IDLE;
        end else if (rd_stb && sel_a) begin
            rdata <= reset_a_reg & WRITABLE_A;
        end else if (rd_stb && sel_b) begin
            rdata <= reset_b_reg & WRITABLE_B;
        end else begin
            rdata <= RDATA_IDLE;
        end
    end

    // Reset lines follow the register bits directly, active high
    assign can_controller_zero_reset = reset_a_reg[BIT_A_CAN_ZERO];
    assign pwm_module_reset = reset_a_reg[BIT_A_PWM];
    assign adc_zero_reset = reset_a_reg[BIT_A_ADC0];
    assign hibernation_unit_reset = reset_a_reg[BIT_A_HIBERNATE];
    assign watchdog_unit_reset = reset_a_reg[BIT_A_WDOG];
    assign comparator_two_reset = reset_b_reg[BIT_B_CMP_TWO];
    assign comparator_one_reset = reset_b_reg[BIT_B_CMP_ONE];
    assign comparator_zero_reset = reset_b_reg[BIT_B_CMP_ZERO];
    assign gp_timer_two_reset = reset_b_reg[BIT_B_GPT_TWO];
    assign gp_timer_one_reset = reset_b_reg[BIT_B_GPT_ONE];
    assign gp_timer_zero_reset = reset_b_reg[BIT_B_GPT_ZERO];
    assign two_wire_unit_zero_reset = reset_b_reg[BIT_B_TWI0];
    assign quadrature_decoder_zero_reset = reset_b_reg[BIT_B_QDEC0];
    assign sync_serial_zero_reset = reset_b_reg[BIT_B_SSER0];
    assign async_serial_two_reset = reset_b_reg[BIT_B_ASER2];
    assign async_serial_one_reset = reset_b_reg[BIT_B_ASER1];
    assign async_serial_zero_reset = reset_b_reg[BIT_B_ASER0];

    // Assertions
    a_masked_write_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (wr_stb && sel_a) |=> ((reset_a_reg & ~$past(wmask_a)) == ($past(reset_a_reg) & ~$past(wmask_a))))
        else $error("Masked bit of register a changed on write");
    a_masked_write_b: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (wr_stb && sel_b) |=> ((reset_b_reg & ~$past(wmask_b)) == ($past(reset_b_reg) & ~$past(wmask_b))))
        else $error("Masked bit of register b changed on write");
    a_write_takes_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (wr_stb && sel_a) |=> ((reset_a_reg & $past(wmask_a)) == ($past(wdata) & $past(wmask_a))))
        else $error("Write to register a not taken");
    a_write_takes_b: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (wr_stb && sel_b) |=> ((reset_b_reg & $past(wmask_b)) == ($past(wdata) & $past(wmask_b))))
        else $error("Write to register b not taken");
    a_read_back_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (rd_stb && sel_a && !wr_stb) |=> (rdata == ($past(reset_a_reg) & WRITABLE_A)))
        else $error("Read of register a wrong");
    a_reserved_zero: assert property (@(posedge clk_sys) disable iff (!rst_b)
        ((reset_a_reg & ~WRITABLE_A) == 32'h0000_0000) && ((reset_b_reg & ~WRITABLE_B) == 32'h0000_0000))
        else $error("Reserved bit set");
    a_unmapped_zero: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (rd_stb && !sel_a && !sel_b) |=> (rdata == 32'h0000_0000))
        else $error("Unmapped read not zero");
    a_wdog_follows: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (wr_stb && sel_a && wmask_a[BIT_A_WDOG]) |=> (watchdog_unit_reset == $past(wdata[BIT_A_WDOG])))
        else $error("Watchdog reset does not follow write");
    a_uart_follows: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (wr_stb && sel_b && wmask_b[BIT_B_ASER0]) |=> (async_serial_zero_reset == $past(wdata[BIT_B_ASER0])))
        else $error("Async serial zero reset does not follow write");
    a_hold_reset: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (can_controller_zero_reset && !(wr_stb && sel_a)) |=> can_controller_zero_reset)
        else $error("CAN reset released without a write");
    a_reset_clears: assert property (@(posedge clk_sys)
        !rst_b |=> (reset_b_reg == RESET_B_INIT && reset_a_reg == RESET_A_INIT))
        else $error("Registers not cleared by reset");
    a_read_back_b: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (rd_stb && sel_b && !wr_stb) |=> (rdata == ($past(reset_b_reg) & WRITABLE_B)))
        else $error("Read of register b wrong");
    a_rdata_idle: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !rd_stb |=> (rdata == RDATA_IDLE))
        else $error("Read data stand outside the read cycle");

    // Per line: a present unit follows the write (watchdog and async serial zero checked above), an absent one and an idle bus keep it
    a_can_write: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (wr_stb && sel_a && wmask_a[BIT_A_CAN_ZERO])
        |=> (can_controller_zero_reset == $past(wdata[BIT_A_CAN_ZERO])))
        else $error("CAN reset does not follow write");
    a_can_masked: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (wr_stb && sel_a && !wmask_a[BIT_A_CAN_ZERO])
        |=> $stable(can_controller_zero_reset))
        else $error("Absent CAN reset changed");
    a_can_kept: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !(wr_stb && sel_a) |=> $stable(can_controller_zero_reset))
        else $error("CAN reset changed without a write");

    a_pwm_write: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (wr_stb && sel_a && wmask_a[BIT_A_PWM])
        |=> (pwm_module_reset == $past(wdata[BIT_A_PWM])))
        else $error("PWM reset does not follow write");
    a_pwm_masked: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (wr_stb && sel_a && !wmask_a[BIT_A_PWM])
        |=> $stable(pwm_module_reset))
        else $error("Absent PWM reset changed");
    a_pwm_kept: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !(wr_stb && sel_a) |=> $stable(pwm_module_reset))
        else $error("PWM reset changed without a write");

    a_adc_write: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (wr_stb && sel_a && wmask_a[BIT_A_ADC0])
        |=> (adc_zero_reset == $past(wdata[BIT_A_ADC0])))
        else $error("ADC reset does not follow write");
    a_adc_masked: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (wr_stb && sel_a && !wmask_a[BIT_A_ADC0])
        |=> $stable(adc_zero_reset))
        else $error("Absent ADC reset changed");
    a_adc_kept: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !(wr_stb && sel_a) |=> $stable(adc_zero_reset))
        else $error("ADC reset changed without a write");

    a_hibernate_write: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (wr_stb && sel_a && wmask_a[BIT_A_HIBERNATE])
        |=> (hibernation_unit_reset == $past(wdata[BIT_A_HIBERNATE])))
        else $error("Hibernation reset does not follow write");
    a_hibernate_masked: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (wr_stb && sel_a && !wmask_a[BIT_A_HIBERNATE])
        |=> $stable(hibernation_unit_reset))
        else $error("Absent hibernation reset changed");
    a_hibernate_kept: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !(wr_stb && sel_a) |=> $stable(hibernation_unit_reset))
        else $error("Hibernation reset changed without a write");

    a_wdog_masked: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (wr_stb && sel_a && !wmask_a[BIT_A_WDOG])
        |=> $stable(watchdog_unit_reset))
        else $error("Absent watchdog reset changed");
    a_wdog_kept: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !(wr_stb && sel_a) |=> $stable(watchdog_unit_reset))
        else $error("Watchdog reset changed without a write");

    a_cmp_two_write: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (wr_stb && sel_b && wmask_b[BIT_B_CMP_TWO])
        |=> (comparator_two_reset == $past(wdata[BIT_B_CMP_TWO])))
        else $error("Comparator two reset does not follow write");
    a_cmp_two_masked: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (wr_stb && sel_b && !wmask_b[BIT_B_CMP_TWO])
        |=> $stable(comparator_two_reset))
        else $error("Absent comparator two reset changed");
    a_cmp_two_kept: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !(wr_stb && sel_b) |=> $stable(comparator_two_reset))
        else $error("Comparator two reset changed without a write");

    a_cmp_one_write: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (wr_stb && sel_b && wmask_b[BIT_B_CMP_ONE])
        |=> (comparator_one_reset == $past(wdata[BIT_B_CMP_ONE])))
        else $error("Comparator one reset does not follow write");
    a_cmp_one_masked: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (wr_stb && sel_b && !wmask_b[BIT_B_CMP_ONE])
        |=> $stable(comparator_one_reset))
        else $error("Absent comparator one reset changed");
    a_cmp_one_kept: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !(wr_stb && sel_b) |=> $stable(comparator_one_reset))
        else $error("Comparator one reset changed without a write");

    a_cmp_zero_write: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (wr_stb && sel_b && wmask_b[BIT_B_CMP_ZERO])
        |=> (comparator_zero_reset == $past(wdata[BIT_B_CMP_ZERO])))
        else $error("Comparator zero reset does not follow write");
    a_cmp_zero_masked: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (wr_stb && sel_b && !wmask_b[BIT_B_CMP_ZERO])
        |=> $stable(comparator_zero_reset))
        else $error("Absent comparator zero reset changed");
    a_cmp_zero_kept: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !(wr_stb && sel_b) |=> $stable(comparator_zero_reset))
        else $error("Comparator zero reset changed without a write");

    a_gpt_two_write: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (wr_stb && sel_b && wmask_b[BIT_B_GPT_TWO])
        |=> (gp_timer_two_reset == $past(wdata[BIT_B_GPT_TWO])))
        else $error("Timer two reset does not follow write");
    a_gpt_two_masked: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (wr_stb && sel_b && !wmask_b[BIT_B_GPT_TWO])
        |=> $stable(gp_timer_two_reset))
        else $error("Absent timer two reset changed");
    a_gpt_two_kept: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !(wr_stb && sel_b) |=> $stable(gp_timer_two_reset))
        else $error("Timer two reset changed without a write");

    a_gpt_one_write: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (wr_stb && sel_b && wmask_b[BIT_B_GPT_ONE])
        |=> (gp_timer_one_reset == $past(wdata[BIT_B_GPT_ONE])))
        else $error("Timer one reset does not follow write");
    a_gpt_one_masked: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (wr_stb && sel_b && !wmask_b[BIT_B_GPT_ONE])
        |=> $stable(gp_timer_one_reset))
        else $error("Absent timer one reset changed");
    a_gpt_one_kept: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !(wr_stb && sel_b) |=> $stable(gp_timer_one_reset))
        else $error("Timer one reset changed without a write");

    a_gpt_zero_write: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (wr_stb && sel_b && wmask_b[BIT_B_GPT_ZERO])
        |=> (gp_timer_zero_reset == $past(wdata[BIT_B_GPT_ZERO])))
        else $error("Timer zero reset does not follow write");
    a_gpt_zero_masked: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (wr_stb && sel_b && !wmask_b[BIT_B_GPT_ZERO])
        |=> $stable(gp_timer_zero_reset))
        else $error("Absent timer zero reset changed");
    a_gpt_zero_kept: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !(wr_stb && sel_b) |=> $stable(gp_timer_zero_reset))
        else $error("Timer zero reset changed without a write");

    a_twi_write: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (wr_stb && sel_b && wmask_b[BIT_B_TWI0])
        |=> (two_wire_unit_zero_reset == $past(wdata[BIT_B_TWI0])))
        else $error("Two-wire reset does not follow write");
    a_twi_masked: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (wr_stb && sel_b && !wmask_b[BIT_B_TWI0])
        |=> $stable(two_wire_unit_zero_reset))
        else $error("Absent two-wire reset changed");
    a_twi_kept: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !(wr_stb && sel_b) |=> $stable(two_wire_unit_zero_reset))
        else $error("Two-wire reset changed without a write");

    a_qdec_write: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (wr_stb && sel_b && wmask_b[BIT_B_QDEC0])
        |=> (quadrature_decoder_zero_reset == $past(wdata[BIT_B_QDEC0])))
        else $error("Quadrature decoder reset does not follow write");
    a_qdec_masked: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (wr_stb && sel_b && !wmask_b[BIT_B_QDEC0])
        |=> $stable(quadrature_decoder_zero_reset))
        else $error("Absent quadrature decoder reset changed");
    a_qdec_kept: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !(wr_stb && sel_b) |=> $stable(quadrature_decoder_zero_reset))
        else $error("Quadrature decoder reset changed without a write");

    a_sser_write: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (wr_stb && sel_b && wmask_b[BIT_B_SSER0])
        |=> (sync_serial_zero_reset == $past(wdata[BIT_B_SSER0])))
        else $error("Sync serial reset does not follow write");
    a_sser_masked: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (wr_stb && sel_b && !wmask_b[BIT_B_SSER0])
        |=> $stable(sync_serial_zero_reset))
        else $error("Absent sync serial reset changed");
    a_sser_kept: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !(wr_stb && sel_b) |=> $stable(sync_serial_zero_reset))
        else $error("Sync serial reset changed without a write");

    a_aser_two_write: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (wr_stb && sel_b && wmask_b[BIT_B_ASER2])
        |=> (async_serial_two_reset == $past(wdata[BIT_B_ASER2])))
        else $error("Async serial two reset does not follow write");
    a_aser_two_masked: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (wr_stb && sel_b && !wmask_b[BIT_B_ASER2])
        |=> $stable(async_serial_two_reset))
        else $error("Absent async serial two reset changed");
    a_aser_two_kept: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !(wr_stb && sel_b) |=> $stable(async_serial_two_reset))
        else $error("Async serial two reset changed without a write");

    a_aser_one_write: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (wr_stb && sel_b && wmask_b[BIT_B_ASER1])
        |=> (async_serial_one_reset == $past(wdata[BIT_B_ASER1])))
        else $error("Async serial one reset does not follow write");
    a_aser_one_masked: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (wr_stb && sel_b && !wmask_b[BIT_B_ASER1])
        |=> $stable(async_serial_one_reset))
        else $error("Absent async serial one reset changed");
    a_aser_one_kept: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !(wr_stb && sel_b) |=> $stable(async_serial_one_reset))
        else $error("Async serial one reset changed without a write");

    a_aser_zero_masked: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (wr_stb && sel_b && !wmask_b[BIT_B_ASER0])
        |=> $stable(async_serial_zero_reset))
        else $error("Absent async serial zero reset changed");
    a_aser_zero_kept: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !(wr_stb && sel_b) |=> $stable(async_serial_zero_reset))
        else $error("Async serial zero reset changed without a write");

    c_write_a: cover property (@(posedge clk_sys) disable iff (!rst_b) wr_stb && sel_a);
    c_masked_b: cover property (@(posedge clk_sys) disable iff (!rst_b)
        wr_stb && sel_b && ((wdata & WRITABLE_B & ~capability_mask_b) != 32'h0000_0000));
    c_read_b: cover property (@(posedge clk_sys) disable iff (!rst_b) rd_stb && sel_b);
    c_release: cover property (@(posedge clk_sys) disable iff (!rst_b)
        $fell(watchdog_unit_reset));
    c_absent_a: cover property (@(posedge clk_sys) disable iff (!rst_b)
        wr_stb && sel_a && !capability_mask_a[BIT_A_WDOG]);
endmodule // periph_reset_ctrl
`default_nettype wire

// ### src/periph_reset_pkg.sv
// Register map, field positions and reset values of the peripheral reset control block
package periph_reset_pkg;
    localparam logic [31:0] SYSCTL_BASE = 32'h400f_e000;
    localparam logic [11:0] OFFSET_RESET_A = 12'h040;
    localparam logic [11:0] OFFSET_RESET_B = 12'h044;
    localparam logic [31:0] RESET_A_INIT = 32'h0000_0000;
    localparam logic [31:0] RESET_B_INIT = 32'h0000_0000;
    localparam logic [31:0] RDATA_IDLE = 32'h0000_0000;
    localparam int REG_ADDR_WIDTH = 12;
    localparam int REG_DATA_WIDTH = 32;

    localparam int BIT_A_CAN_ZERO = 24;
    localparam int BIT_A_PWM = 20;
    localparam int BIT_A_ADC0 = 16;
    localparam int BIT_A_HIBERNATE = 6;
    localparam int BIT_A_WDOG = 3;

    localparam int BIT_B_CMP_TWO = 26;
    localparam int BIT_B_CMP_ONE = 25;
    localparam int BIT_B_CMP_ZERO = 24;
    localparam int BIT_B_GPT_TWO = 18;
    localparam int BIT_B_GPT_ONE = 17;
    localparam int BIT_B_GPT_ZERO = 16;
    localparam int BIT_B_TWI0 = 12;
    localparam int BIT_B_QDEC0 = 8;
    localparam int BIT_B_SSER0 = 4;
    localparam int BIT_B_ASER2 = 2;
    localparam int BIT_B_ASER1 = 1;
    localparam int BIT_B_ASER0 = 0;

    // Writable bits; everything else is reserved and reads zero
    localparam logic [31:0] WRITABLE_A = 32'h0111_0048;
    localparam logic [31:0] WRITABLE_B = 32'h0707_1117;
endpackage
